// >>> rtl/tmc_edge_det.sv
// Pin synchroniser and rise/fall pulse detector
`timescale 1ns/1ps
module tmc_edge_det
	import tmc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Asynchronous pin
	input wire logic pin,
	// Edge pulses
	output logic rise,
	output logic fall
);

	tmc_edge_state_t s_q;
	tmc_edge_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.sync1 = pin;
		s_d.sync2 = s_q.sync1;
		s_d.prev = s_q.sync2;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rise = s_q.sync2 & ~s_q.prev;
	assign fall = ~s_q.sync2 & s_q.prev;

endmodule

// >>> rtl/tmc_pkg.sv
// Types shared by the timer channel control modules
package tmc_pkg;
`include "tmc_regs.svh"

	typedef enum logic [1:0] {
		TMC_OP_STOP,
		TMC_OP_FREE,
		TMC_OP_EDGE_CLR,
		TMC_OP_MATCH_CLR
	} tmc_op_t;

	typedef struct packed {
		logic [`TMC_CNT_W-1:0] cnt;
		logic [`TMC_CNT_W-1:0] cc1;
		logic [`TMC_CNT_W-1:0] cc2;
		tmc_op_t op;
		logic tog_cond;
		logic ovf;
		logic [2:0] crc;
		logic tog_out;
		logic irq;
		logic [7:0] rdata;
	} tmc_state_t;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
	} tmc_edge_state_t;

endpackage

// >>> rtl/tmc_regs.svh
// Register offsets, field positions, reset values and widths of the timer channel control
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

`define TMC_ADDR_MODE 16'hffad
`define TMC_ADDR_CCCTL 16'hffbc
`define TMC_RST_MODE 8'h00
`define TMC_RST_CCCTL 8'h00
`define TMC_CNT_W 16
`define TMC_OVF_BIT 0
`define TMC_TOG_BIT 1
`define TMC_OP_LO_BIT 2
`define TMC_OP_HI_BIT 3
`define TMC_CC1_ROLE_BIT 0
`define TMC_TRIG_SEL_BIT 1
`define TMC_CC2_ROLE_BIT 2
`define TMC_ES_FALL 2'b00
`define TMC_ES_RISE 2'b01
`define TMC_ES_BOTH 2'b11

`endif

// >>> rtl/tmc_top.sv
// Timer channel mode control, compare/capture control and 16-bit counter
//
// How it works
// - Operation field 00 stops the channel and holds the counter at zero.
// - Field 01 runs free; field 10 clears counter on valid primary pin edge.
// - Field 11 clears and restarts counter when it equals first register.
// - Toggle condition 0: output inverts on either compare match.
// - Toggle condition 1: output inverts on matches and valid primary edges too.
// - Overflow flag sets when counter wraps from all ones to zero.
// - Overflow flag clears on software write of 0 or when operation is 00.
// - Software writing 1 to overflow flag sets it.
// - Active trigger edges come from the prescaler edge-select field bits 5:4.
// - Capture/compare control takes bit and byte writes; reset gives 00.
// - Bits 0 and 2 pick compare (0) or capture (1) for each register.
// - Trigger select 0 captures first register on secondary edge, 1 on opposite primary edge.
// - Both-edges primary select with trigger select 1 detects no primary edge.
// - Trigger select 1: secondary edge raises first interrupt, no capture.
`timescale 1ns/1ps
`include "tmc_regs.svh"
module tmc_top
	import tmc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register access
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_bit_wr,
	input wire logic [2:0] bus_bit_pos,
	input wire logic bus_bit_val,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	// Capture/compare register load
	input wire logic cc1_wr,
	input wire logic cc2_wr,
	input wire logic [`TMC_CNT_W-1:0] cc_wdata,
	// Prescaler side
	input wire logic count_tick,
	input wire logic [1:0] edge_sel_prim,
	input wire logic [1:0] edge_sel_sec,
	// Trigger pins
	input wire logic primary_trigger_pin,
	input wire logic secondary_trigger_pin,
	// Outputs
	output logic toggle_output_pin,
	output logic first_match_interrupt,
	output logic [`TMC_CNT_W-1:0] counter_value,
	output logic [`TMC_CNT_W-1:0] first_cc_register,
	output logic [`TMC_CNT_W-1:0] second_cc_register,
	output logic overflow_flag
);

	localparam logic [`TMC_CNT_W-1:0] CNT_MAX = '1;

	tmc_state_t s_q;
	tmc_state_t s_d;
	logic prim_rise, prim_fall, sec_rise, sec_fall;
	logic prim_valid, prim_rev, sec_valid;
	logic run, tick_run, match1, match2, ovf_evt, cap1, cap2, sec_irq, tog_evt;
	logic hit_mode, hit_ccctl;
	logic [7:0] mode_cur, mode_new, ccctl_cur, ccctl_new;

	// ------------------------------------------------------------
	// Pin edge detection
	// ------------------------------------------------------------
	tmc_edge_det u_prim (
		.clk(clk),
		.rst(rst),
		.pin(primary_trigger_pin),
		.rise(prim_rise),
		.fall(prim_fall)
	);

	tmc_edge_det u_sec (
		.clk(clk),
		.rst(rst),
		.pin(secondary_trigger_pin),
		.rise(sec_rise),
		.fall(sec_fall)
	);

	// Valid edge for a select code; rev picks the opposite phase
	function automatic logic edge_hit(input logic [1:0] es, input logic r, input logic f,
			input logic rev);
		logic hit;
		hit = 1'b0;
		unique case (es)
			`TMC_ES_FALL: hit = rev ? r : f;
			`TMC_ES_RISE: hit = rev ? f : r;
			`TMC_ES_BOTH: hit = rev ? 1'b0 : (r | f);
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Byte write or single-bit write onto a register image
	function automatic logic [7:0] apply_write(input logic [7:0] old, input logic hit,
			input logic wr, input logic [7:0] wdata, input logic bwr,
			input logic [2:0] pos, input logic bval);
		logic [7:0] r;
		r = old;
		if (hit && wr) begin
			r = wdata;
		end else if (hit && bwr) begin
			r[pos] = bval;
		end
		return r;
	endfunction

	assign prim_valid = edge_hit(edge_sel_prim, prim_rise, prim_fall, 1'b0)
		& ~(s_q.crc[`TMC_TRIG_SEL_BIT] & (edge_sel_prim == `TMC_ES_BOTH));
	assign prim_rev = edge_hit(edge_sel_prim, prim_rise, prim_fall, 1'b1);
	assign sec_valid = edge_hit(edge_sel_sec, sec_rise, sec_fall, 1'b0);

	// ------------------------------------------------------------
	// Events
	// ------------------------------------------------------------
	assign run = (s_q.op != TMC_OP_STOP);
	assign tick_run = count_tick & run;
	assign match1 = tick_run & ~s_q.crc[`TMC_CC1_ROLE_BIT] & (s_q.cnt == s_q.cc1);
	assign match2 = tick_run & ~s_q.crc[`TMC_CC2_ROLE_BIT] & (s_q.cnt == s_q.cc2);
	assign ovf_evt = tick_run & (s_q.cnt == CNT_MAX);
	assign cap1 = run & s_q.crc[`TMC_CC1_ROLE_BIT]
		& (s_q.crc[`TMC_TRIG_SEL_BIT] ? prim_rev : sec_valid);
	assign cap2 = run & s_q.crc[`TMC_CC2_ROLE_BIT] & prim_valid;
	assign sec_irq = run & s_q.crc[`TMC_TRIG_SEL_BIT] & sec_valid;
	assign tog_evt = match1 | match2 | (s_q.tog_cond & run & prim_valid);

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	assign hit_mode = (bus_addr == `TMC_ADDR_MODE);
	assign hit_ccctl = (bus_addr == `TMC_ADDR_CCCTL);
	assign mode_cur = {4'h0, s_q.op, s_q.tog_cond, s_q.ovf};
	assign ccctl_cur = {5'h00, s_q.crc};
	assign mode_new = apply_write(mode_cur, hit_mode, bus_wr, bus_wdata, bus_bit_wr,
		bus_bit_pos, bus_bit_val);
	assign ccctl_new = apply_write(ccctl_cur, hit_ccctl, bus_wr, bus_wdata, bus_bit_wr,
		bus_bit_pos, bus_bit_val);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.op = tmc_op_t'(mode_new[`TMC_OP_HI_BIT:`TMC_OP_LO_BIT]);
		s_d.tog_cond = mode_new[`TMC_TOG_BIT];
		s_d.ovf = mode_new[`TMC_OVF_BIT];
		s_d.crc = ccctl_new[2:0];
		if (ovf_evt) begin
			s_d.ovf = 1'b1;
		end
		if (s_d.op == TMC_OP_STOP) begin
			s_d.ovf = 1'b0;
		end
		if (s_d.op == TMC_OP_STOP) begin
			s_d.cnt = '0;
		end else if ((s_q.op == TMC_OP_EDGE_CLR) && prim_valid) begin
			s_d.cnt = '0;
		end else if (tick_run) begin
			if ((s_q.op == TMC_OP_MATCH_CLR) && (s_q.cnt == s_q.cc1)) begin
				s_d.cnt = '0;
			end else begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end
		if (cc1_wr) begin
			s_d.cc1 = cc_wdata;
		end
		if (cap1) begin
			s_d.cc1 = s_q.cnt;
		end
		if (cc2_wr) begin
			s_d.cc2 = cc_wdata;
		end
		if (cap2) begin
			s_d.cc2 = s_q.cnt;
		end
		if (tog_evt) begin
			s_d.tog_out = ~s_q.tog_out;
		end
		s_d.irq = match1 | cap1 | sec_irq;
		if (bus_rd) begin
			s_d.rdata = hit_mode ? mode_cur : (hit_ccctl ? ccctl_cur : 8'h00);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus_rdata = s_q.rdata;
	assign toggle_output_pin = s_q.tog_out;
	assign first_match_interrupt = s_q.irq;
	assign counter_value = s_q.cnt;
	assign first_cc_register = s_q.cc1;
	assign second_cc_register = s_q.cc2;
	assign overflow_flag = s_q.ovf;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_stop_clear;
		(s_q.op == TMC_OP_STOP) |-> (s_q.cnt == '0) && !s_q.ovf;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stopped but counter or flag set");

	property p_free_inc;
		(s_q.op == TMC_OP_FREE) && count_tick && (s_d.op == TMC_OP_FREE)
			|=> s_q.cnt == $past(s_q.cnt) + 1'b1;
	endproperty
	a_free_inc: assert property (p_free_inc) else $error("free run did not increment");

	property p_edge_clr;
		(s_q.op == TMC_OP_EDGE_CLR) && prim_valid && (s_d.op != TMC_OP_STOP) |=> s_q.cnt == '0;
	endproperty
	a_edge_clr: assert property (p_edge_clr) else $error("edge did not clear counter");

	property p_match_clr;
		(s_q.op == TMC_OP_MATCH_CLR) && count_tick && (s_q.cnt == s_q.cc1)
			&& (s_d.op == TMC_OP_MATCH_CLR) |=> s_q.cnt == '0;
	endproperty
	a_match_clr: assert property (p_match_clr) else $error("match did not clear counter");

	property p_toggle;
		(match1 || match2) |=> toggle_output_pin != $past(toggle_output_pin);
	endproperty
	a_toggle: assert property (p_toggle) else $error("match did not toggle output");

	property p_toggle_edge;
		run && s_q.tog_cond && prim_valid |=> toggle_output_pin != $past(toggle_output_pin);
	endproperty
	a_toggle_edge: assert property (p_toggle_edge) else $error("edge did not toggle output");

	property p_ovf_set;
		ovf_evt && (s_d.op != TMC_OP_STOP) |=> overflow_flag;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("wrap did not set overflow");

	property p_ovf_sw;
		hit_mode && bus_wr && !ovf_evt
			|=> overflow_flag == ($past(bus_wdata[`TMC_OVF_BIT]) && (s_q.op != TMC_OP_STOP));
	endproperty
	a_ovf_sw: assert property (p_ovf_sw) else $error("overflow write not applied");

	property p_capture;
		cap1 && !cc1_wr ##1 !cap1 && !cc1_wr |=> first_cc_register == $past(s_q.cnt, 2);
	endproperty
	a_capture: assert property (p_capture) else $error("capture value not held");

	property p_sec_irq;
		sec_irq && !cc1_wr && !cap1
			|=> first_match_interrupt && first_cc_register == $past(s_q.cc1);
	endproperty
	a_sec_irq: assert property (p_sec_irq) else $error("secondary edge not an interrupt");

	property p_both_none;
		s_q.crc[`TMC_TRIG_SEL_BIT] && (edge_sel_prim == `TMC_ES_BOTH) |-> !prim_valid && !prim_rev;
	endproperty
	a_both_none: assert property (p_both_none) else $error("edge seen with both-edge select");

endmodule

// >>> testbench/timer_mode_and_capture_control_test.sv
// Self-checking bench for the timer channel control
`timescale 1ns/1ps
`include "tmc_regs.svh"
module timer_mode_and_capture_control_test;
	import tmc_pkg::*;
	logic clk = 1'b0;
	logic rst;
	logic [15:0] bus_addr, cc_wdata;
	logic bus_wr, bus_bit_wr, bus_bit_val, bus_rd;
	logic [7:0] bus_wdata, bus_rdata;
	logic [2:0] bus_bit_pos;
	logic cc1_wr, cc2_wr, count_tick;
	logic [1:0] edge_sel_prim, edge_sel_sec;
	logic prim, sec, toggle_output_pin, first_match_interrupt, overflow_flag, tg;
	logic [15:0] counter_value, first_cc_register, second_cc_register;
	int n_fail = 0, checks = 0, n_irq = 0, cyc = 0, irq0;

	always #4 clk = ~clk;

	tmc_top tmc_top_inst (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_wdata(bus_wdata), .bus_bit_wr(bus_bit_wr), .bus_bit_pos(bus_bit_pos),
		.bus_bit_val(bus_bit_val), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cc1_wr(cc1_wr),
		.cc2_wr(cc2_wr), .cc_wdata(cc_wdata), .count_tick(count_tick),
		.edge_sel_prim(edge_sel_prim), .edge_sel_sec(edge_sel_sec),
		.primary_trigger_pin(prim), .secondary_trigger_pin(sec),
		.toggle_output_pin(toggle_output_pin), .first_match_interrupt(first_match_interrupt),
		.counter_value(counter_value), .first_cc_register(first_cc_register),
		.second_cc_register(second_cc_register), .overflow_flag(overflow_flag));

	tmc_pin_model tmc_pin_model_inst (.clk(clk), .primary_trigger_pin(prim),
		.secondary_trigger_pin(sec));

	// -----------------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
	endtask

	task automatic bwr(input logic [15:0] a, input logic [2:0] p, input logic v);
		@(negedge clk);
		bus_addr = a;
		bus_bit_pos = p;
		bus_bit_val = v;
		bus_bit_wr = 1'b1;
		@(negedge clk);
		bus_bit_wr = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge clk);
		bus_rd = 1'b0;
		d = bus_rdata;
	endtask

	task automatic ld(input logic second, input logic [15:0] v);
		@(negedge clk);
		cc_wdata = v;
		cc1_wr = ~second;
		cc2_wr = second;
		@(negedge clk);
		cc1_wr = 1'b0;
		cc2_wr = 1'b0;
	endtask

	task automatic ticks(input int n);
		@(negedge clk);
		count_tick = 1'b1;
		repeat (n) @(negedge clk);
		count_tick = 1'b0;
	endtask

	task automatic final_report();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Interrupt pulses counted mid-cycle, away from the launching edge
	always @(negedge clk) begin
		if (first_match_interrupt === 1'b1) begin
			n_irq <= n_irq + 1;
		end
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_fail++;
			final_report();
		end
	end

	// -----------------------------------------------------------------
	// Tests
	// -----------------------------------------------------------------
	initial begin
		logic [7:0] d;
		rst = 1'b1;
		bus_addr = 16'h0000;
		cc_wdata = 16'h0000;
		bus_wr = 1'b0;
		bus_bit_wr = 1'b0;
		bus_bit_val = 1'b0;
		bus_rd = 1'b0;
		bus_wdata = 8'h00;
		bus_bit_pos = 3'h0;
		cc1_wr = 1'b0;
		cc2_wr = 1'b0;
		count_tick = 1'b0;
		edge_sel_prim = 2'b01;
		edge_sel_sec = 2'b01;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		rd(`TMC_ADDR_MODE, d); chk(16'(d), 16'h0000);
		rd(`TMC_ADDR_CCCTL, d); chk(16'(d), 16'h0000);
		rd(16'hffae, d); chk(16'(d), 16'h0000);
		ld(1'b1, 16'h1234);
		// Free run and overflow
		wr(`TMC_ADDR_MODE, 8'h04);
		ticks(9); chk(counter_value, 16'h0009);
		ticks(65527); chk(counter_value, 16'h0000);
		chk(16'(overflow_flag), 16'h0001);
		rd(`TMC_ADDR_MODE, d); chk(16'(d), 16'h0005);
		bwr(`TMC_ADDR_MODE, 3'h0, 1'b0); chk(16'(overflow_flag), 16'h0000);
		bwr(`TMC_ADDR_MODE, 3'h0, 1'b1); chk(16'(overflow_flag), 16'h0001);
		wr(`TMC_ADDR_MODE, 8'h00); chk(16'(overflow_flag), 16'h0000);
		ticks(3); chk(counter_value, 16'h0000);
		// Clear on first register match
		ld(1'b0, 16'h0005);
		wr(`TMC_ADDR_MODE, 8'h0c);
		tg = toggle_output_pin;
		irq0 = n_irq;
		ticks(7); chk(counter_value, 16'h0001);
		chk(16'(toggle_output_pin), 16'(!tg));
		chk(16'(n_irq - irq0), 16'h0001);
		// Clear on primary pin edge
		wr(`TMC_ADDR_MODE, 8'h00);
		wr(`TMC_ADDR_MODE, 8'h08);
		ticks(10); chk(counter_value, 16'h000a);
		tg = toggle_output_pin;
		tmc_pin_model_inst.pulse(1'b0); chk(counter_value, 16'h0000);
		chk(16'(toggle_output_pin), 16'(tg));
		wr(`TMC_ADDR_MODE, 8'h0a);
		ticks(3);
		tmc_pin_model_inst.pulse(1'b0); chk(16'(toggle_output_pin), 16'(!tg));
		edge_sel_prim = 2'b10;
		ticks(3);
		tmc_pin_model_inst.pulse(1'b0); chk(counter_value, 16'h0003);
		// Capture, control changed only while stopped
		wr(`TMC_ADDR_MODE, 8'h00);
		edge_sel_prim = 2'b01;
		wr(`TMC_ADDR_CCCTL, 8'h01);
		bwr(`TMC_ADDR_CCCTL, 3'h2, 1'b1);
		rd(`TMC_ADDR_CCCTL, d); chk(16'(d), 16'h0005);
		wr(`TMC_ADDR_MODE, 8'h04);
		ticks(20);
		tmc_pin_model_inst.pulse(1'b1); chk(first_cc_register, 16'h0014);
		ticks(5);
		tmc_pin_model_inst.pulse(1'b0); chk(second_cc_register, 16'h0019);
		chk(first_cc_register, 16'h0014);
		// Secondary pin on falling edge select: one pulse captures counter 0x1d
		edge_sel_sec = 2'b00;
		ticks(4);
		tmc_pin_model_inst.pulse(1'b1); chk(first_cc_register, 16'h001d);
		wr(`TMC_ADDR_MODE, 8'h00);
		bwr(`TMC_ADDR_CCCTL, 3'h1, 1'b1);
		wr(`TMC_ADDR_MODE, 8'h04);
		ticks(7);
		irq0 = n_irq;
		tmc_pin_model_inst.pulse(1'b1); chk(first_cc_register, 16'h001d);
		chk(16'(n_irq - irq0), 16'h0001);
		tmc_pin_model_inst.pulse(1'b0); chk(first_cc_register, 16'h0007);
		edge_sel_prim = 2'b11;
		ticks(2);
		tmc_pin_model_inst.pulse(1'b0); chk(first_cc_register, 16'h0007);
		final_report();
	end
endmodule

// >>> testbench/tmc_pin_model.sv
// Model of the external party driving the two trigger input pins
`timescale 1ns/1ps
module tmc_pin_model (
	// Clock
	input wire logic clk,
	// Trigger pins
	output logic primary_trigger_pin,
	output logic secondary_trigger_pin
);
	initial begin
		primary_trigger_pin = 1'b0;
		secondary_trigger_pin = 1'b0;
	end

	// -----------------------------------------------------------------
	// One whole pulse, high held four clocks, then low held six
	// -----------------------------------------------------------------
	task automatic pulse(input logic sec);
		@(negedge clk);
		if (sec) begin
			secondary_trigger_pin = 1'b1;
		end else begin
			primary_trigger_pin = 1'b1;
		end
		repeat (4) @(negedge clk);
		primary_trigger_pin = 1'b0;
		secondary_trigger_pin = 1'b0;
		repeat (6) @(negedge clk);
	endtask
endmodule
